// ---- pkg/mie_pkg.sv ----
package mie_pkg;

  localparam int DATA_W    = 8;
  localparam int ADDR_W    = 8;
  localparam int PC_W      = 12;
  localparam int OPC_W     = 4;

  // Operation codes presented on the instruction port
  localparam logic [3:0] OP_NOP       = 4'h0;
  localparam logic [3:0] OP_SLEEP     = 4'h1;
  localparam logic [3:0] OP_INC_MEM   = 4'h2;
  localparam logic [3:0] OP_INC_WREG  = 4'h3;
  localparam logic [3:0] OP_DEC_WREG  = 4'h4;
  localparam logic [3:0] OP_BRANCH    = 4'h5;
  localparam logic [3:0] OP_LOAD_MEM  = 4'h6;
  localparam logic [3:0] OP_LOAD_IMM  = 4'h7;
  localparam logic [3:0] OP_STORE     = 4'h8;

  localparam logic [7:0] WREG_RST     = 8'h00;
  localparam logic [11:0] PC_RST      = 12'h000;
  localparam logic [7:0] ONE_B        = 8'h01;
  localparam logic [11:0] ONE_PC      = 12'h001;

  typedef enum logic [2:0] {
    MIE_RUN    = 3'b001,
    MIE_BUBBLE = 3'b010,
    MIE_HALT   = 3'b100
  } mie_state_t;

endpackage : mie_pkg

// ---- rtl/mie_sync2.sv ----
`timescale 1ns/100ps
module mie_sync2 (
  input  wire logic sys_clk,
  input  wire logic arst_n,
  input  wire logic din,
  output logic      dout
);
  logic stage1_reg;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1_reg <= 1'b0;
      dout       <= 1'b0;
    end else begin
      stage1_reg <= din;
      dout       <= stage1_reg;
    end
  end
endmodule : mie_sync2

// ---- rtl/mie_exec.sv ----
`timescale 1ns/100ps
module mie_exec
  import mie_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              arst_n,
  input  wire logic              instr_valid,
  input  wire logic [OPC_W-1:0]  instr_op,
  input  wire logic [ADDR_W-1:0] instr_addr,
  input  wire logic [DATA_W-1:0] instr_imm,
  input  wire logic [PC_W-1:0]   instr_target,
  input  wire logic [DATA_W-1:0] mem_rdata,
  input  wire logic              wake_pin,
  output logic                   instr_ready,
  output logic [ADDR_W-1:0]      mem_addr,
  output logic                   mem_we,
  output logic [DATA_W-1:0]      mem_wdata,
  output logic [PC_W-1:0]        pc_reg,
  output logic [DATA_W-1:0]      working_register,
  output logic                   zero_flag,
  output logic                   power_down_flag,
  output logic                   watchdog_timeout_flag,
  output logic                   watchdog_timer_clear,
  output logic                   sys_clk_gate_off,
  output logic                   dummy_cycle
);

  mie_state_t state_reg;
  mie_state_t state_next;
  logic       wake_sync;

  mie_sync2 u_wake (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .din     (wake_pin),
    .dout    (wake_sync)
  );

  wire       in_run    = (state_reg == MIE_RUN);
  wire       issue     = in_run && instr_valid;
  wire       is_sleep  = issue && (instr_op == OP_SLEEP);
  wire       is_incm   = issue && (instr_op == OP_INC_MEM);
  wire       is_incw   = issue && (instr_op == OP_INC_WREG);
  wire       is_decw   = issue && (instr_op == OP_DEC_WREG);
  wire       is_branch = issue && (instr_op == OP_BRANCH);
  wire       is_ldm    = issue && (instr_op == OP_LOAD_MEM);
  wire       is_ldi    = issue && (instr_op == OP_LOAD_IMM);
  wire       is_store  = issue && (instr_op == OP_STORE);

  wire [DATA_W-1:0] inc_val = mem_rdata + ONE_B;
  wire [DATA_W-1:0] dec_val = mem_rdata - ONE_B;
  wire [DATA_W-1:0] alu_val = is_decw ? dec_val : inc_val;
  wire              alu_zero = (alu_val == 8'h00);
  wire              zero_upd = is_incm || is_incw || is_decw;

  assign instr_ready = in_run;
  assign mem_addr    = instr_addr;
  assign mem_we      = is_incm || is_store;
  assign mem_wdata   = is_store ? working_register : inc_val;
  assign sys_clk_gate_off = (state_reg == MIE_HALT);
  assign dummy_cycle      = (state_reg == MIE_BUBBLE);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      MIE_RUN: begin
        if (is_branch)
          state_next = MIE_BUBBLE;
        else if (is_sleep)
          state_next = MIE_HALT;
      end
      MIE_BUBBLE: state_next = MIE_RUN;
      MIE_HALT: begin
        if (wake_sync)
          state_next = MIE_RUN;
      end
      default: state_next = MIE_RUN;
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n)
      state_reg <= MIE_RUN;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n)
      pc_reg <= PC_RST;
    else if (is_branch)
      pc_reg <= instr_target;
    else if (issue)
      pc_reg <= pc_reg + ONE_PC;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n)
      working_register <= WREG_RST;
    else if (is_incw || is_decw)
      working_register <= alu_val;
    else if (is_ldm)
      working_register <= mem_rdata;
    else if (is_ldi)
      working_register <= instr_imm;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n)
      zero_flag <= 1'b0;
    else if (zero_upd)
      zero_flag <= alu_zero;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      power_down_flag       <= 1'b0;
      watchdog_timeout_flag <= 1'b0;
    end else if (is_sleep) begin
      power_down_flag       <= 1'b1;
      watchdog_timeout_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n)
      watchdog_timer_clear <= 1'b0;
    else
      watchdog_timer_clear <= is_sleep;
  end

  sleep_flags_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    is_sleep |=> power_down_flag && !watchdog_timeout_flag
      && watchdog_timer_clear && sys_clk_gate_off)
    else $error("sleep did not set flags");

  halt_holds_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    sys_clk_gate_off && !wake_sync |=> sys_clk_gate_off
      && $stable(working_register) && $stable(pc_reg))
    else $error("halt state not held");

  wdt_clear_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    watchdog_timer_clear |-> $past(is_sleep))
    else $error("watchdog clear without sleep");

  inc_mem_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    is_incm |-> mem_we && mem_wdata == mem_rdata + ONE_B)
    else $error("increment write wrong");

  inc_wreg_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    is_incw |-> !mem_we ##1
      working_register == $past(mem_rdata) + ONE_B)
    else $error("add one into working register wrong");

  dec_wreg_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    is_decw |-> !mem_we ##1
      working_register == $past(mem_rdata) - ONE_B)
    else $error("subtract one into working register wrong");

  branch_pc_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    is_branch |=> pc_reg == $past(instr_target)
      && $stable(zero_flag))
    else $error("branch target not loaded");

  branch_bubble_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    is_branch |=> dummy_cycle && !instr_ready ##1 instr_ready)
    else $error("branch not two cycles");

  load_mem_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    is_ldm |=> working_register == $past(mem_rdata)
      && $stable(zero_flag))
    else $error("load from memory wrong");

  load_imm_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    is_ldi |=> working_register == $past(instr_imm)
      && $stable(zero_flag))
    else $error("load immediate wrong");

  store_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    is_store |-> mem_we && mem_wdata == working_register)
    else $error("store data wrong");

  zero_flag_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    zero_upd |=> zero_flag == ($past(alu_val) == 8'h00))
    else $error("zero flag wrong");

endmodule : mie_exec

// ---- tb/mie_mem_model.sv ----
`timescale 1ns/100ps
module mie_mem_model
  import mie_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic [ADDR_W-1:0] mem_addr,
  input  wire logic              mem_we,
  input  wire logic [DATA_W-1:0] mem_wdata,
  output logic      [DATA_W-1:0] mem_rdata
);
  logic [DATA_W-1:0] mem [256];
  // Unwritten bytes hold the inverse of their address, non-zero except at 8'hff
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = ~i[7:0];
    end
  end
  assign mem_rdata = mem[mem_addr];
  always @(posedge sys_clk) begin
    if (mem_we === 1'b1) begin
      mem[mem_addr] <= mem_wdata;
    end
  end
endmodule : mie_mem_model

// ---- tb/tb_top.sv ----
`timescale 1ns/100ps
module tb_top
  import mie_pkg::*;
;
  logic              sys_clk, arst_n, instr_valid, wake_pin, instr_ready;
  logic [OPC_W-1:0]  instr_op;
  logic [ADDR_W-1:0] instr_addr, mem_addr;
  logic [DATA_W-1:0] instr_imm, mem_rdata, mem_wdata, working_register;
  logic [PC_W-1:0]   instr_target, pc_reg;
  logic              mem_we, zero_flag, power_down_flag, dummy_cycle;
  logic              watchdog_timeout_flag, watchdog_timer_clear;
  logic              sys_clk_gate_off;
  int                fails, compares;

  mie_exec dut (.sys_clk(sys_clk), .arst_n(arst_n),
    .instr_valid(instr_valid), .instr_op(instr_op),
    .instr_addr(instr_addr), .instr_imm(instr_imm),
    .instr_target(instr_target), .mem_rdata(mem_rdata),
    .wake_pin(wake_pin), .instr_ready(instr_ready), .mem_addr(mem_addr),
    .mem_we(mem_we), .mem_wdata(mem_wdata), .pc_reg(pc_reg),
    .working_register(working_register), .zero_flag(zero_flag),
    .power_down_flag(power_down_flag),
    .watchdog_timeout_flag(watchdog_timeout_flag),
    .watchdog_timer_clear(watchdog_timer_clear),
    .sys_clk_gate_off(sys_clk_gate_off), .dummy_cycle(dummy_cycle));
  mie_mem_model mem_m (.sys_clk(sys_clk), .mem_addr(mem_addr),
    .mem_we(mem_we), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input string n, input logic [11:0] e, s);
    compares++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // Offer at a falling edge, hold until taken; valid stays up after
  task automatic issue(input logic [3:0] op, input logic [7:0] a, d,
                       input logic [11:0] t = 12'h000);
    instr_valid = 1'b1;
    instr_op = op;
    instr_addr = a;
    instr_imm = d;
    instr_target = t;
    while (instr_ready !== 1'b1) @(negedge sys_clk);
    @(negedge sys_clk);
  endtask : issue

  task automatic t_move;
    issue(OP_LOAD_IMM, 8'h00, 8'h5a);
    chk("wreg imm", 12'h05a, working_register);
    issue(OP_STORE, 8'h10, 8'h00);
    chk("mem st", 12'h05a, mem_m.mem[8'h10]);
    issue(OP_LOAD_IMM, 8'h00, 8'h00);
    issue(OP_LOAD_MEM, 8'h10, 8'h00);
    chk("wreg ld", 12'h05a, working_register);
    chk("zero kept", 12'h000, zero_flag);
    $display("t_move done");
  endtask : t_move

  task automatic t_incdec;
    issue(OP_LOAD_IMM, 8'h00, 8'hff);
    issue(OP_STORE, 8'h20, 8'h00);
    issue(OP_INC_MEM, 8'h20, 8'h00);
    chk("inc mem", 12'h000, mem_m.mem[8'h20]);
    chk("zero set", 12'h001, zero_flag);
    issue(OP_INC_WREG, 8'h20, 8'h00);
    chk("inca wreg", 12'h001, working_register);
    chk("inca mem", 12'h000, mem_m.mem[8'h20]);
    chk("zero clr", 12'h000, zero_flag);
    issue(OP_STORE, 8'h21, 8'h00);
    issue(OP_DEC_WREG, 8'h21, 8'h00);
    chk("deca wreg", 12'h000, working_register);
    chk("deca mem", 12'h001, mem_m.mem[8'h21]);
    chk("deca zero", 12'h001, zero_flag);
    $display("t_incdec done");
  endtask : t_incdec

  task automatic t_branch;
    issue(OP_BRANCH, 8'h00, 8'h00, 12'h3a5);
    chk("pc tgt", 12'h3a5, pc_reg);
    chk("dummy", 12'h001, dummy_cycle);
    chk("bubble", 12'h000, instr_ready);
    chk("br zero", 12'h001, zero_flag);
    @(negedge sys_clk);
    chk("ready back", 12'h001, instr_ready);
    issue(OP_NOP, 8'h00, 8'h00);
    chk("pc next", 12'h3a6, pc_reg);
    $display("t_branch done");
  endtask : t_branch

  task automatic t_sleep;
    issue(OP_SLEEP, 8'h00, 8'h00);
    chk("pdf", 12'h001, power_down_flag);
    chk("to", 12'h000, watchdog_timeout_flag);
    chk("wdt clr", 12'h001, watchdog_timer_clear);
    chk("gate off", 12'h001, sys_clk_gate_off);
    chk("halted", 12'h000, instr_ready);
    chk("zero kept", 12'h001, zero_flag);
    repeat (4) @(negedge sys_clk);
    chk("still off", 12'h001, sys_clk_gate_off);
    chk("wreg kept", 12'h000, working_register);
    wake_pin = 1'b1;
    for (int i = 0; i < 6 && sys_clk_gate_off !== 1'b0; i++)
      @(negedge sys_clk);
    wake_pin = 1'b0;
    chk("woken", 12'h000, sys_clk_gate_off);
    issue(OP_LOAD_IMM, 8'h00, 8'h33);
    chk("run again", 12'h033, working_register);
    $display("t_sleep done");
  endtask : t_sleep

  task automatic wrap_up;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up

  initial begin
    #20000;
    fails++;
    wrap_up();
  end

  initial begin
    {arst_n, instr_valid, wake_pin, instr_op} = '0;
    {instr_addr, instr_imm, instr_target} = '0;
    repeat (3) @(negedge sys_clk);
    arst_n = 1'b1;
    chk("pc rst", PC_RST, pc_reg);
    chk("ready rst", 12'h001, instr_ready);
    t_move();
    t_incdec();
    t_branch();
    t_sleep();
    wrap_up();
  end
endmodule : tb_top
